// ---- common/sock_regs_pkg.sv ----
// constants, register map and state types shared by the socket register bank
package sock_regs_pkg;
  localparam int NUM_SOCKETS = 8;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int LEN_W = 15;
  localparam int MAC_W = 48;

  // register map
  localparam logic [15:0] ADDR_PHY_STATUS = 16'h0035;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h0036;
  localparam logic [15:0] MODE_BASE = 16'h4000;
  localparam logic [15:0] MODE_STRIDE = 16'h0100;
  localparam logic [15:0] MODE_SPAN = 16'h0800;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // phy status fields
  localparam int PHY_LINK_BIT = 5;
  localparam int PHY_SLEEP_BIT = 3;

  // interrupt mask fields
  localparam int MASK_CONFLICT_BIT = 7;
  localparam int MASK_PPPOE_BIT = 5;
  localparam logic [7:0] IRQ_MASK_WMASK = 8'hA0;

  // socket mode fields
  localparam int MODE_MULTI_BIT = 7;
  localparam int MODE_FILTER_BIT = 6;
  localparam int MODE_ACKVER_BIT = 5;
  localparam int MODE_PROTO_MSB = 3;
  localparam logic [7:0] MODE_WMASK = 8'hEF;

  // protocol codes
  localparam logic [3:0] PROTO_CLOSED = 4'h0;
  localparam logic [3:0] PROTO_TCP = 4'h1;
  localparam logic [3:0] PROTO_UDP = 4'h2;
  localparam logic [3:0] PROTO_RAW_IP = 4'h3;
  localparam logic [3:0] PROTO_RAW_ETH = 4'h4;
  localparam logic [3:0] PROTO_PPPOE = 4'h5;

  // socket status after open
  localparam logic [7:0] STAT_CLOSED = 8'h00;
  localparam logic [7:0] STAT_TCP_OPENED = 8'h13;
  localparam logic [7:0] STAT_UDP_OPENED = 8'h22;
  localparam logic [7:0] STAT_RAW_IP_OPENED = 8'h32;

  localparam logic [47:0] BROADCAST_MAC = 48'hFFFFFFFFFFFF;

  // serial frame control word: top bit is the write flag, the rest the byte count
  localparam int CTRL_WRITE_BIT = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    FR_ADDR_HI,
    FR_ADDR_LO,
    FR_CTRL_HI,
    FR_CTRL_LO,
    FR_DATA,
    FR_DONE
  } frame_e;
endpackage

// ---- core/spi_byte_port.sv ----
// serial byte port: pin synchronisers, mode 0 shift in and shift out
`timescale 1ns/1ps
module spi_byte_port
  import sock_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sclkPin,
  input wire logic mosiPin,
  input wire logic selPinN,
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic frameActive,
  output logic misoOut,
  output logic misoOe
);
  import sock_regs_pkg::*;

  typedef struct packed {
    logic [2:0] sclkSync;
    logic [2:0] mosiSync;
    logic [2:0] selSync;
    logic sclkLvl;
    logic mosiLvl;
    logic selLvlN;
    logic [7:0] shiftIn;
    logic [2:0] bitCnt;
    logic [7:0] rxByte;
    logic rxValid;
    logic [7:0] shiftOut;
    logic miso;
  } port_s;

  port_s q;
  port_s d;

  always_comb begin
    logic rise;
    logic fall;
    rise = 1'b0;
    fall = 1'b0;
    d = q;
    d.rxValid = 1'b0;
    d.sclkSync = {q.sclkSync[1:0], sclkPin};
    d.mosiSync = {q.mosiSync[1:0], mosiPin};
    d.selSync = {q.selSync[1:0], selPinN};
    // a pin level counts only once the second and third stages agree
    if (q.sclkSync[1] == q.sclkSync[2]) begin
      d.sclkLvl = q.sclkSync[2];
      rise = q.sclkSync[2] & ~q.sclkLvl;
      fall = ~q.sclkSync[2] & q.sclkLvl;
    end
    if (q.mosiSync[1] == q.mosiSync[2]) begin
      d.mosiLvl = q.mosiSync[2];
    end
    if (q.selSync[1] == q.selSync[2]) begin
      d.selLvlN = q.selSync[2];
    end
    if (q.selLvlN) begin
      d.bitCnt = '0;
      d.shiftOut = '0;
      d.miso = 1'b0;
    end else begin
      // mosi is three stages late like sclk, so the held level matches the edge
      if (rise) begin
        d.shiftIn = {q.shiftIn[6:0], q.mosiLvl};
        d.bitCnt = q.bitCnt + 3'h1;
        if (q.bitCnt == LAST_BIT) begin
          d.rxByte = {q.shiftIn[6:0], q.mosiLvl};
          d.rxValid = 1'b1;
        end
      end
      // the next byte is loaded on the first falling edge after a byte boundary
      if (fall) begin
        if (q.bitCnt == '0) begin
          d.miso = txByte[7];
          d.shiftOut = {txByte[6:0], 1'b0};
        end else begin
          d.miso = q.shiftOut[7];
          d.shiftOut = {q.shiftOut[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.sclkLvl <= 1'b0;
      q.selLvlN <= 1'b1;
      q.selSync <= 3'h7;
    end else begin
      q <= d;
    end
  end

  assign rxByte = q.rxByte;
  assign rxValid = q.rxValid;
  assign frameActive = ~q.selLvlN;
  assign misoOut = q.miso;
  assign misoOe = ~q.selLvlN;
endmodule

// ---- core/socket_mode_phy_status_regs.sv ----
// socket mode, interrupt mask and phy status registers behind the serial port
// Function
// - phy status bit 5 shows link up, read only, writes ignored.
// - phy status bit 3 shows phy power-down, read only.
// - conflict and pppoe-close interrupts raised only when flag set and mask bit 1.
// - mode bit 7 enables multicast, effective only in udp.
// - raw ethernet with filter set accepts own-address or broadcast frames only.
// - raw ethernet with filter clear accepts every frame.
// - tcp with mode bit 5 set acknowledges each segment immediately.
// - tcp with mode bit 5 clear delays acknowledges by internal timeout.
// - udp multicast, mode bit 5 picks igmp version: 0 v2, 1 v1.
// - mode bits 3..0 decode closed, tcp, udp, raw ip; raw ethernet and pppoe on socket 0 only, closed elsewhere.
// - socket 0 pppoe is temporary; it may be reprogrammed afterwards.
// - eight mode registers at 0x4000 plus 0x100 per socket, reset 0x00.
// - open sets status 0x13 for tcp and 0x22 for udp.
`timescale 1ns/1ps
module socket_mode_phy_status_regs
  import sock_regs_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic sclkPin,
  input wire logic mosiPin,
  input wire logic selPinN,
  output logic misoOut,
  output logic misoOe,
  input wire logic linkUpPin,
  input wire logic phySleepPin,
  input wire logic addrConflictFlag,
  input wire logic pppoeCloseFlag,
  output logic irqReq,
  input wire logic [sock_regs_pkg::NUM_SOCKETS-1:0] sockOpenReq,
  output logic [sock_regs_pkg::NUM_SOCKETS-1:0][7:0] sockStatus,
  output logic [sock_regs_pkg::NUM_SOCKETS-1:0][3:0] sockProtocol,
  output logic [sock_regs_pkg::NUM_SOCKETS-1:0] multicastOn,
  output logic [sock_regs_pkg::NUM_SOCKETS-1:0] immediateAck,
  output logic [sock_regs_pkg::NUM_SOCKETS-1:0] delayedAck,
  output logic [sock_regs_pkg::NUM_SOCKETS-1:0] igmpV1,
  input wire logic rxFrameValid,
  input wire logic [sock_regs_pkg::MAC_W-1:0] rxFrameDstMac,
  input wire logic [sock_regs_pkg::MAC_W-1:0] ownMac,
  output logic rxFrameAccept,
  output logic rxFrameDone
);
  import sock_regs_pkg::*;

  typedef struct packed {
    logic [2:0] linkSync;
    logic [2:0] sleepSync;
    logic linkLvl;
    logic sleepLvl;
    logic [7:0] irqMask;
    logic [NUM_SOCKETS-1:0][7:0] mode;
    logic [NUM_SOCKETS-1:0][7:0] status;
    frame_e state;
    logic [ADDR_W-1:0] addr;
    logic isWrite;
    logic [LEN_W-1:0] remain;
    logic frameAccept;
    logic frameDone;
  } bank_s;

  bank_s q;
  bank_s d;

  logic [7:0] rxByte;
  logic rxValid;
  logic frameActive;
  logic [7:0] txByte;

  // true when the address names one of the eight mode registers
  function automatic logic isModeAddr(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - MODE_BASE;
    isModeAddr = (a >= MODE_BASE) && (off < MODE_SPAN) && (off[7:0] == '0);
  endfunction

  function automatic logic [2:0] modeSocket(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - MODE_BASE;
    modeSocket = off[10:8];
  endfunction

  // protocol as the socket engines see it; codes a socket lacks act as closed
  function automatic logic [3:0] effProto(input logic [7:0] m, input int sock);
    logic [3:0] p;
    p = m[MODE_PROTO_MSB:0];
    effProto = PROTO_CLOSED;
    case (p)
      PROTO_TCP, PROTO_UDP, PROTO_RAW_IP: effProto = p;
      PROTO_RAW_ETH, PROTO_PPPOE: effProto = (sock == 0) ? p : PROTO_CLOSED;
      default: effProto = PROTO_CLOSED;
    endcase
  endfunction

  spi_byte_port u_port (
    .clk(clk),
    .srst(srst),
    .sclkPin(sclkPin),
    .mosiPin(mosiPin),
    .selPinN(selPinN),
    .txByte(txByte),
    .rxByte(rxByte),
    .rxValid(rxValid),
    .frameActive(frameActive),
    .misoOut(misoOut),
    .misoOe(misoOe)
  );

  // read path, from the current address
  always_comb begin
    txByte = RESET_BYTE;
    if (q.state == FR_DATA && !q.isWrite) begin
      if (q.addr == ADDR_PHY_STATUS) begin
        txByte[PHY_LINK_BIT] = q.linkLvl;
        txByte[PHY_SLEEP_BIT] = q.sleepLvl;
      end else if (q.addr == ADDR_IRQ_MASK) begin
        txByte = q.irqMask;
      end else if (isModeAddr(q.addr)) begin
        txByte = q.mode[modeSocket(q.addr)];
      end
    end
  end

  always_comb begin
    logic [3:0] p0;
    p0 = PROTO_CLOSED;
    d = q;
    d.frameAccept = 1'b0;
    d.frameDone = 1'b0;
    d.linkSync = {q.linkSync[1:0], linkUpPin};
    d.sleepSync = {q.sleepSync[1:0], phySleepPin};
    if (q.linkSync[1] == q.linkSync[2]) begin
      d.linkLvl = q.linkSync[2];
    end
    if (q.sleepSync[1] == q.sleepSync[2]) begin
      d.sleepLvl = q.sleepSync[2];
    end

    if (!frameActive) begin
      d.state = FR_ADDR_HI;
    end else if (rxValid) begin
      case (q.state)
        FR_ADDR_HI: begin
          d.addr[15:8] = rxByte;
          d.state = FR_ADDR_LO;
        end
        FR_ADDR_LO: begin
          d.addr[7:0] = rxByte;
          d.state = FR_CTRL_HI;
        end
        FR_CTRL_HI: begin
          d.isWrite = rxByte[CTRL_WRITE_BIT];
          d.remain[14:8] = rxByte[6:0];
          d.state = FR_CTRL_LO;
        end
        FR_CTRL_LO: begin
          d.remain[7:0] = rxByte;
          d.state = ({q.remain[14:8], rxByte} == '0) ? FR_DONE : FR_DATA;
        end
        FR_DATA: begin
          if (q.isWrite) begin
            if (q.addr == ADDR_IRQ_MASK) begin
              d.irqMask = rxByte & IRQ_MASK_WMASK;
            end else if (isModeAddr(q.addr)) begin
              d.mode[modeSocket(q.addr)] = rxByte & MODE_WMASK;
            end
            // phy status writes fall through here unused
          end
          d.addr = q.addr + 16'h0001;
          d.remain = q.remain - 15'h0001;
          if (q.remain == 15'h0001) begin
            d.state = FR_DONE;
          end
        end
        FR_DONE: d.state = FR_DONE;
        default: d.state = FR_ADDR_HI;
      endcase
    end

    for (int s = 0; s < NUM_SOCKETS; s++) begin
      if (sockOpenReq[s]) begin
        case (effProto(q.mode[s], s))
          PROTO_TCP: d.status[s] = STAT_TCP_OPENED;
          PROTO_UDP: d.status[s] = STAT_UDP_OPENED;
          PROTO_RAW_IP: d.status[s] = STAT_RAW_IP_OPENED;
          default: d.status[s] = STAT_CLOSED;
        endcase
      end
    end

    // one verdict per offered frame, only meaningful to raw ethernet socket 0
    if (rxFrameValid) begin
      p0 = effProto(q.mode[0], 0);
      d.frameDone = 1'b1;
      if (p0 == PROTO_RAW_ETH) begin
        if (q.mode[0][MODE_FILTER_BIT]) begin
          d.frameAccept = (rxFrameDstMac == ownMac) || (rxFrameDstMac == BROADCAST_MAC);
        end else begin
          d.frameAccept = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.state <= FR_ADDR_HI;
    end else begin
      q <= d;
    end
  end

  // per socket option decode
  always_comb begin
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      sockProtocol[s] = effProto(q.mode[s], s);
      multicastOn[s] = q.mode[s][MODE_MULTI_BIT] && (sockProtocol[s] == PROTO_UDP);
      immediateAck[s] = q.mode[s][MODE_ACKVER_BIT] && (sockProtocol[s] == PROTO_TCP);
      delayedAck[s] = !q.mode[s][MODE_ACKVER_BIT] && (sockProtocol[s] == PROTO_TCP);
      igmpV1[s] = multicastOn[s] && q.mode[s][MODE_ACKVER_BIT];
    end
  end

  assign irqReq = (addrConflictFlag && q.irqMask[MASK_CONFLICT_BIT]) ||
                  (pppoeCloseFlag && q.irqMask[MASK_PPPOE_BIT]);

  assign sockStatus = q.status;
  assign rxFrameAccept = q.frameAccept;
  assign rxFrameDone = q.frameDone;
endmodule

// ---- sim/socket_mode_phy_status_regs_assertions.sv ----
// port-level checks for the socket mode, mask and phy status bank
`timescale 1ns/1ps
module sock_regs_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic irqReq,
  input wire logic addrConflictFlag,
  input wire logic pppoeCloseFlag,
  input wire logic [sock_regs_pkg::NUM_SOCKETS-1:0] sockOpenReq,
  input wire logic [sock_regs_pkg::NUM_SOCKETS-1:0][7:0] sockStatus,
  input wire logic [sock_regs_pkg::NUM_SOCKETS-1:0][3:0] sockProtocol,
  input wire logic [sock_regs_pkg::NUM_SOCKETS-1:0] multicastOn,
  input wire logic [sock_regs_pkg::NUM_SOCKETS-1:0] immediateAck,
  input wire logic [sock_regs_pkg::NUM_SOCKETS-1:0] delayedAck,
  input wire logic [sock_regs_pkg::NUM_SOCKETS-1:0] igmpV1,
  input wire logic rxFrameValid,
  input wire logic [sock_regs_pkg::MAC_W-1:0] rxFrameDstMac,
  input wire logic [sock_regs_pkg::MAC_W-1:0] ownMac,
  input wire logic rxFrameAccept,
  input wire logic rxFrameDone
);
  import sock_regs_pkg::*;
  logic [NUM_SOCKETS-1:0] isUdp, isTcp;
  logic upperOk;
  always_comb begin
    upperOk = 1'b1;
    for (int s = 0; s < NUM_SOCKETS; s++) begin
      isUdp[s] = sockProtocol[s] == PROTO_UDP;
      isTcp[s] = sockProtocol[s] == PROTO_TCP;
      if (s > 0 && sockProtocol[s] > PROTO_RAW_IP) upperOk = 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_irq_needs_flag: assert property (!addrConflictFlag && !pppoeCloseFlag |-> !irqReq)
    else $error("irq without flag");
  a_multi_only_udp: assert property ((multicastOn & ~isUdp) == '0)
    else $error("multicast outside udp");
  a_ack_split: assert property ((immediateAck ^ delayedAck) == isTcp)
    else $error("ack mode wrong");
  a_igmp_in_multi: assert property ((igmpV1 & ~multicastOn) == '0)
    else $error("igmp v1 without multicast");
  a_upper_sockets: assert property (upperOk)
    else $error("raw codes on upper socket");
  a_done_follows: assert property (rxFrameValid |=> rxFrameDone)
    else $error("frame verdict missing");
  a_accept_raw: assert property (rxFrameValid && sockProtocol[0] != PROTO_RAW_ETH |=> !rxFrameAccept)
    else $error("accept outside raw mode");
  a_accept_own: assert property (rxFrameValid && sockProtocol[0] == PROTO_RAW_ETH
    && (rxFrameDstMac == ownMac || rxFrameDstMac == BROADCAST_MAC) |=> rxFrameAccept)
    else $error("own frame refused");
  a_open_tcp: assert property (sockOpenReq[0] && isTcp[0] |=> sockStatus[0] == STAT_TCP_OPENED)
    else $error("tcp open status");
  a_open_udp: assert property (sockOpenReq[1] && isUdp[1] |=> sockStatus[1] == STAT_UDP_OPENED)
    else $error("udp open status");
  a_status_holds: assert property (!sockOpenReq[0] |=> $stable(sockStatus[0]))
    else $error("status moved");
  c_irq: cover property (irqReq);
  c_accept: cover property (rxFrameAccept);
  c_igmp: cover property (igmpV1[2]);
endmodule

// ---- sim/spi_host_model.sv ----
// host side serial master: mode 0 frames of one data byte
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  input wire logic misoOut,
  input wire logic misoOe,
  output logic sclkPin,
  output logic mosiPin,
  output logic selPinN
);
  // five clocks a phase keeps every pin edge visible to the synchronisers
  localparam int HALF = 5;
  initial begin
    sclkPin = 1'b0;
    mosiPin = 1'b0;
    selPinN = 1'b1;
  end
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosiPin <= tx[i];
      repeat (HALF) @(posedge clk);
      rx[i] = misoOe ? misoOut : 1'bx;
      sclkPin <= 1'b1;
      repeat (HALF) @(posedge clk);
      sclkPin <= 1'b0;
    end
  endtask
  task automatic frame(input logic wr, input logic [15:0] a, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] junk;
    @(posedge clk);
    selPinN <= 1'b0;
    repeat (HALF) @(posedge clk);
    shift(a[15:8], junk);
    shift(a[7:0], junk);
    shift({wr, 7'h00}, junk);
    shift(8'h01, junk);
    shift(wd, rd);
    repeat (HALF) @(posedge clk);
    selPinN <= 1'b1;
    // a released line does not keep its last level
    mosiPin <= ~mosiPin;
    repeat (2 * HALF) @(posedge clk);
  endtask
endmodule

// ---- sim/tb_socket_mode_phy_status_regs.sv ----
// self-checking bench for the socket mode, mask and phy status registers
`timescale 1ns/1ps
module tb_socket_mode_phy_status_regs;
  import sock_regs_pkg::*;
  logic clk, srst, sclkPin, mosiPin, selPinN, misoOut, misoOe, irqReq;
  logic linkUpPin, phySleepPin, addrConflictFlag, pppoeCloseFlag;
  logic [NUM_SOCKETS-1:0] sockOpenReq, multicastOn, immediateAck, delayedAck, igmpV1;
  logic [NUM_SOCKETS-1:0][7:0] sockStatus;
  logic [NUM_SOCKETS-1:0][3:0] sockProtocol;
  logic rxFrameValid, rxFrameAccept, rxFrameDone;
  logic [MAC_W-1:0] rxFrameDstMac, ownMac;
  logic [7:0] rd;
  int errCount, checks;
  socket_mode_phy_status_regs u_socket_mode_phy_status_regs (.clk(clk), .srst(srst), .sclkPin(sclkPin),
    .mosiPin(mosiPin), .selPinN(selPinN), .misoOut(misoOut), .misoOe(misoOe), .linkUpPin(linkUpPin),
    .phySleepPin(phySleepPin), .addrConflictFlag(addrConflictFlag), .pppoeCloseFlag(pppoeCloseFlag),
    .irqReq(irqReq), .sockOpenReq(sockOpenReq), .sockStatus(sockStatus), .sockProtocol(sockProtocol),
    .multicastOn(multicastOn), .immediateAck(immediateAck), .delayedAck(delayedAck), .igmpV1(igmpV1),
    .rxFrameValid(rxFrameValid), .rxFrameDstMac(rxFrameDstMac), .ownMac(ownMac),
    .rxFrameAccept(rxFrameAccept), .rxFrameDone(rxFrameDone));
  spi_host_model u_spi_host_model (.clk(clk), .misoOut(misoOut), .misoOe(misoOe), .sclkPin(sclkPin),
    .mosiPin(mosiPin), .selPinN(selPinN));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] maddr(input int s);
    return 16'(MODE_BASE + MODE_STRIDE * s);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    u_spi_host_model.frame(1'b1, a, d, rd);
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    u_spi_host_model.frame(1'b0, a, 8'h00, rd);
    chk(rd, e);
  endtask
  task automatic open_sock(input int s);
    sockOpenReq <= NUM_SOCKETS'(1) << s;
    @(posedge clk);
    sockOpenReq <= '0;
    #1;
  endtask
  task automatic irq_case(input logic c, input logic p, input logic e);
    @(posedge clk);
    addrConflictFlag <= c;
    pppoeCloseFlag <= p;
    #1;
    chk({7'h00, irqReq}, {7'h00, e});
  endtask
  task automatic offer(input logic [MAC_W-1:0] m, input logic e);
    @(posedge clk);
    rxFrameValid <= 1'b1;
    rxFrameDstMac <= m;
    @(posedge clk);
    rxFrameValid <= 1'b0;
    rxFrameDstMac <= ~m;
    #1;
    chk({6'h00, rxFrameDone, rxFrameAccept}, {6'h00, 1'b1, e});
  endtask
  task automatic opt_case(input logic [7:0] m, input logic [3:0] e);
    wr(maddr(2), m);
    chk({4'h0, multicastOn[2], igmpV1[2], immediateAck[2], delayedAck[2]}, {4'h0, e});
  endtask
  task automatic t_reset;
    rdchk(ADDR_PHY_STATUS, 8'h00);
    rdchk(ADDR_IRQ_MASK, 8'h00);
    for (int s = 0; s < NUM_SOCKETS; s++) rdchk(maddr(s), 8'h00);
  endtask
  task automatic t_phy;
    linkUpPin <= 1'b1;
    rdchk(ADDR_PHY_STATUS, 8'h20);
    linkUpPin <= 1'b0;
    phySleepPin <= 1'b1;
    rdchk(ADDR_PHY_STATUS, 8'h08);
    wr(ADDR_PHY_STATUS, 8'hFF);
    rdchk(ADDR_PHY_STATUS, 8'h08);
  endtask
  task automatic t_irq;
    irq_case(1'b1, 1'b1, 1'b0);
    wr(ADDR_IRQ_MASK, 8'hFF);
    rdchk(ADDR_IRQ_MASK, 8'hA0);
    irq_case(1'b1, 1'b0, 1'b1);
    wr(ADDR_IRQ_MASK, 8'h20);
    irq_case(1'b1, 1'b0, 1'b0);
    irq_case(1'b0, 1'b1, 1'b1);
  endtask
  task automatic t_map;
    for (int s = 0; s < NUM_SOCKETS; s++) wr(maddr(s), 8'hD0 | 8'(s));
    for (int s = 0; s < NUM_SOCKETS; s++) rdchk(maddr(s), 8'hC0 | 8'(s));
  endtask
  task automatic t_proto;
    logic [7:0] st;
    for (int c = 0; c < 6; c++) begin
      wr(maddr(0), 8'(c));
      open_sock(0);
      st = c == 1 ? 8'h13 : c == 2 ? 8'h22 : c == 3 ? 8'h32 : 8'h00;
      chk(sockStatus[0], st);
      chk({4'h0, sockProtocol[0]}, 8'(c));
      wr(maddr(1), 8'(c));
      open_sock(1);
      chk(sockStatus[1], st);
      chk({4'h0, sockProtocol[1]}, c > 3 ? 8'h00 : 8'(c));
    end
    wr(maddr(0), 8'h02);
    open_sock(0);
    chk(sockStatus[0], 8'h22);
  endtask
  task automatic t_opts;
    opt_case(8'h82, 4'h8);
    opt_case(8'hA2, 4'hC);
    // group address and port sit outside this bank; the mode is set before the open
    open_sock(2);
    chk(sockStatus[2], 8'h22);
    opt_case(8'h81, 4'h1);
    opt_case(8'hA1, 4'h2);
    opt_case(8'h22, 4'h0);
  endtask
  task automatic t_filter;
    wr(maddr(0), 8'h44);
    offer(ownMac, 1'b1);
    offer(BROADCAST_MAC, 1'b1);
    offer(48'h0A0B0C0D0E0F, 1'b0);
    wr(maddr(0), 8'h04);
    offer(48'h0A0B0C0D0E0F, 1'b1);
    wr(maddr(0), 8'h01);
    offer(ownMac, 1'b0);
  endtask
  task automatic t_rerun;
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk(sockStatus[0], 8'h00);
    // select must stay high a few clocks after release so the pin synchronisers settle
    repeat (4) @(posedge clk);
    rdchk(maddr(0), 8'h00);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    {linkUpPin, phySleepPin, addrConflictFlag, pppoeCloseFlag, rxFrameValid} = '0;
    sockOpenReq = '0;
    rxFrameDstMac = '0;
    ownMac = 48'h02001234ABCD;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset;
    t_phy;
    t_irq;
    t_map;
    t_proto;
    t_opts;
    t_filter;
    t_rerun;
    close_out;
  end
  // about 60 frames of some 420 clocks each, with wide margin
  initial begin
    repeat (90000) @(posedge clk);
    errCount++;
    close_out;
  end
endmodule
bind socket_mode_phy_status_regs sock_regs_checker u_sock_regs_checker (.clk(clk), .srst(srst),
  .irqReq(irqReq), .addrConflictFlag(addrConflictFlag), .pppoeCloseFlag(pppoeCloseFlag),
  .sockOpenReq(sockOpenReq), .sockStatus(sockStatus), .sockProtocol(sockProtocol),
  .multicastOn(multicastOn), .immediateAck(immediateAck), .delayedAck(delayedAck), .igmpV1(igmpV1),
  .rxFrameValid(rxFrameValid), .rxFrameDstMac(rxFrameDstMac), .ownMac(ownMac),
  .rxFrameAccept(rxFrameAccept), .rxFrameDone(rxFrameDone));
